// *** design/ssg_strobe_gen.sv ***
// Sense sample strobe generator with an APB register slave.
// Assumes all inputs synchronous to core_clk_in; PWM status comes from the selected channel.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps
module ssg_strobe_gen #(
    parameter int FALLBACK_HALF = ssg_pkg::FALLBACK_HALF_CYC,
    parameter int HIGH_PULSE = ssg_pkg::HIGH_PULSE_CYC,
    parameter int BLANK = ssg_pkg::BLANK_CYC,
    parameter int CNT_W = 20,
    parameter int ON_W = 16
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic normal_mode_in,
    input wire logic fail_mode_in,
    input wire logic pwm_clk_fail_in,
    input wire logic pwm_tick_in,
    input wire logic pwm_cycle_start_in,
    input wire logic pwm_on_in,
    input wire logic out_switching_in,
    input wire logic full_duty_in,
    input wire logic high_overcurrent_window_in,
    input wire logic out_fault_in,
    input wire logic out_enable_in,
    output logic sense_sample_strobe_o_out,
    output logic sense_sample_strobe_oe_out,
    output logic offset_sign_out
);
    // Counts the counters cannot serve are refused at elaboration
    if (BLANK < 1 || HIGH_PULSE < 1 || FALLBACK_HALF < 1) begin : g_count_check
        $error("Timing counts must be at least one cycle");
    end
    if (FALLBACK_HALF >= (1 << CNT_W) || BLANK >= (1 << CNT_W)
        || HIGH_PULSE >= (1 << CNT_W)) begin : g_width_check
        $error("CNT_W too narrow for timing counts");
    end

    localparam logic [CNT_W-1:0] FB_LAST = CNT_W'(FALLBACK_HALF - 1);
    // The overflow cycle itself is the first cycle of the high pulse
    localparam logic [CNT_W-1:0] HP_LOAD = CNT_W'(HIGH_PULSE - 1);
    localparam logic [CNT_W-1:0] BL_LOAD = CNT_W'(BLANK);

    function automatic logic is_current(input logic [2:0] src);
        return src < ssg_pkg::SRC_FIRST_VOLTAGE;
    endfunction : is_current

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    ssg_pkg::ssg_ctrl_t ctrl_r;
    logic [31:0] rdata_r;
    logic mapped;
    logic wr_ctrl;
    logic mux_chg_r;
    logic strobe_low_r;
    logic chop_sign_r;
    logic fault_r;
    logic [CNT_W-1:0] blank_cnt_r;
    logic chop_active;
    logic strobe_low_nxt;

    assign mapped = paddr_in == ssg_pkg::CTRL_OFFSET || paddr_in == ssg_pkg::STATUS_OFFSET;
    assign wr_ctrl = psel_in && penable_in && pwrite_in && paddr_in == ssg_pkg::CTRL_OFFSET;
    // Zero wait states; read data is captured in the setup cycle
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;
    assign prdata_out = rdata_r;

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            ctrl_r <= ssg_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= pwdata_in[5:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            rdata_r <= 32'h0;
        end else if (psel_in && !penable_in) begin
            rdata_r <= 32'h0;
            if (paddr_in == ssg_pkg::CTRL_OFFSET) begin
                rdata_r[5:0] <= ctrl_r;
            end else if (paddr_in == ssg_pkg::STATUS_OFFSET) begin
                rdata_r[ssg_pkg::ST_STROBE_BIT] <= strobe_low_r;
                rdata_r[ssg_pkg::ST_CHOP_SIGN_BIT] <= chop_sign_r;
                rdata_r[ssg_pkg::ST_FAULT_BIT] <= fault_r;
                rdata_r[ssg_pkg::ST_BLANK_BIT] <= blank_cnt_r != '0;
                rdata_r[ssg_pkg::ST_CHOP_ACT_BIT] <= chop_active;
            end
        end
    end

    // A source change is the multiplexer switching
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            mux_chg_r <= 1'b0;
        end else begin
            mux_chg_r <= wr_ctrl && pwdata_in[4:2] != ctrl_r.feedback_source_select;
        end
    end

    // ----------------------------------------
    // Offset chopping
    // ----------------------------------------
    logic strobe_rise;
    logic chop_sw;
    assign chop_active = ctrl_r.offset_chopping_enable && !fail_mode_in;
    assign strobe_rise = strobe_low_r && !strobe_low_nxt;
    assign chop_sw = chop_active && strobe_rise;

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            chop_sign_r <= 1'b0;
        end else if (chop_sw) begin
            chop_sign_r <= !chop_sign_r;
        end
    end
    assign offset_sign_out = chop_sign_r;

    // ----------------------------------------
    // Blanking, fault latch and cycle tracking
    // ----------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            blank_cnt_r <= '0;
        end else if (mux_chg_r || chop_sw) begin
            blank_cnt_r <= BL_LOAD;
        end else if (blank_cnt_r != '0) begin
            blank_cnt_r <= blank_cnt_r - 1'b1;
        end
    end

    // Set wins over a simultaneous re-enable so no fault is lost
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            fault_r <= 1'b0;
        end else if (out_fault_in) begin
            fault_r <= 1'b1;
        end else if (out_enable_in) begin
            fault_r <= 1'b0;
        end
    end

    logic wait_cycle_r;
    logic wait_mid_r;
    logic [ON_W-1:0] on_cnt_r;
    logic [ON_W-1:0] prev_len_r;
    logic pwm_on_d_r;
    logic second_half;
    assign second_half = pwm_on_in && on_cnt_r >= (prev_len_r >> 1);

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            wait_cycle_r <= 1'b0;
        end else if (mux_chg_r) begin
            wait_cycle_r <= 1'b1;
        end else if (pwm_cycle_start_in) begin
            wait_cycle_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            wait_mid_r <= 1'b0;
        end else if (mux_chg_r) begin
            wait_mid_r <= 1'b1;
        end else if (second_half && blank_cnt_r == '0 && !pwm_on_d_r) begin
            wait_mid_r <= wait_mid_r;
        end else if (second_half && blank_cnt_r == '0 && on_cnt_r == (prev_len_r >> 1)) begin
            wait_mid_r <= 1'b0;
        end
    end

    // Midpoint uses the previous pulse length; duty changes lag one cycle
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            on_cnt_r <= '0;
            prev_len_r <= '0;
            pwm_on_d_r <= 1'b0;
        end else begin
            pwm_on_d_r <= pwm_on_in;
            if (pwm_on_in) begin
                on_cnt_r <= (on_cnt_r == '1) ? on_cnt_r : on_cnt_r + 1'b1;
            end else begin
                on_cnt_r <= '0;
            end
            if (pwm_on_d_r && !pwm_on_in) begin
                prev_len_r <= on_cnt_r;
            end
        end
    end

    // ----------------------------------------
    // Square waves and 100 % duty pulse
    // ----------------------------------------
    logic [9:0] sq_cnt_r;
    logic sq_r;
    logic [CNT_W-1:0] fb_cnt_r;
    logic fb_r;
    logic [CNT_W-1:0] hp_cnt_r;

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            sq_cnt_r <= '0;
            sq_r <= 1'b0;
        end else if (pwm_tick_in) begin
            if (sq_cnt_r == ssg_pkg::SQ_HALF_TICKS) begin
                sq_cnt_r <= '0;
                sq_r <= !sq_r;
            end else begin
                sq_cnt_r <= sq_cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            fb_cnt_r <= '0;
            fb_r <= 1'b0;
        end else if (fb_cnt_r == FB_LAST) begin
            fb_cnt_r <= '0;
            fb_r <= !fb_r;
        end else begin
            fb_cnt_r <= fb_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            hp_cnt_r <= '0;
        end else if (pwm_cycle_start_in && full_duty_in) begin
            hp_cnt_r <= HP_LOAD;
        end else if (hp_cnt_r != '0) begin
            hp_cnt_r <= hp_cnt_r - 1'b1;
        end
    end

    // ----------------------------------------
    // Strobe selection
    // ----------------------------------------
    logic trig_mode;
    assign trig_mode = ctrl_r.strobe_mode == ssg_pkg::SSG_MODE_AFTER_CYCLE
        || ctrl_r.strobe_mode == ssg_pkg::SSG_MODE_SECOND_HALF;

    always_comb begin
        strobe_low_nxt = 1'b0;
        if (!normal_mode_in) begin
            strobe_low_nxt = 1'b0;
        end else if (pwm_clk_fail_in) begin
            strobe_low_nxt = fb_r;
        end else if (!is_current(ctrl_r.feedback_source_select)) begin
            strobe_low_nxt = sq_r;
        end else if (blank_cnt_r != '0 || mux_chg_r || fault_r
            || high_overcurrent_window_in) begin
            strobe_low_nxt = 1'b0;
        end else if (trig_mode && full_duty_in) begin
            strobe_low_nxt = hp_cnt_r == '0 && !pwm_cycle_start_in;
        end else begin
            case (ctrl_r.strobe_mode)
                ssg_pkg::SSG_MODE_OFF: strobe_low_nxt = 1'b0;
                ssg_pkg::SSG_MODE_VALID: strobe_low_nxt = pwm_on_in && !out_switching_in;
                ssg_pkg::SSG_MODE_AFTER_CYCLE: begin
                    strobe_low_nxt = pwm_on_in && !out_switching_in && !wait_cycle_r;
                end
                ssg_pkg::SSG_MODE_SECOND_HALF: begin
                    strobe_low_nxt = second_half && !out_switching_in && !wait_mid_r;
                end
                default: strobe_low_nxt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            strobe_low_r <= 1'b0;
        end else begin
            strobe_low_r <= strobe_low_nxt;
        end
    end

    // drive low only, release for high
    assign sense_sample_strobe_o_out = 1'b0;
    assign sense_sample_strobe_oe_out = strobe_low_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_not_normal;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        !normal_mode_in |=> !sense_sample_strobe_oe_out;
    endproperty
    a_not_normal: assert property (p_not_normal) else $error("strobe outside normal mode");

    property p_mode_off;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (ctrl_r.strobe_mode == ssg_pkg::SSG_MODE_OFF && !pwm_clk_fail_in
            && is_current(ctrl_r.feedback_source_select)) |=> !strobe_low_r;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("strobe active in off mode");

    property p_off_phase;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (normal_mode_in && !pwm_clk_fail_in && is_current(ctrl_r.feedback_source_select)
            && !full_duty_in && (!pwm_on_in || high_overcurrent_window_in)) |=> !strobe_low_r;
    endproperty
    a_off_phase: assert property (p_off_phase) else $error("strobe in off phase or window");

    property p_valid_follow;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (normal_mode_in && !pwm_clk_fail_in && ctrl_r.strobe_mode == ssg_pkg::SSG_MODE_VALID
            && is_current(ctrl_r.feedback_source_select) && blank_cnt_r == '0 && !mux_chg_r
            && !fault_r && !high_overcurrent_window_in && pwm_on_in && !out_switching_in)
            |=> strobe_low_r;
    endproperty
    a_valid_follow: assert property (p_valid_follow) else $error("valid mode not low");

    property p_blank;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (mux_chg_r && !pwm_clk_fail_in && is_current(ctrl_r.feedback_source_select))
            |=> (blank_cnt_r == BL_LOAD) && !strobe_low_r;
    endproperty
    a_blank: assert property (p_blank) else $error("no blank after switch");

    property p_wait_cycle;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        mux_chg_r |=> wait_cycle_r && wait_mid_r;
    endproperty
    a_wait_cycle: assert property (p_wait_cycle) else $error("mux wait not armed");

    property p_fault_hold;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (out_fault_in ##1 (!out_enable_in && normal_mode_in && !pwm_clk_fail_in
            && is_current(ctrl_r.feedback_source_select))) |=> !strobe_low_r;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("trigger after fault");

    property p_fallback_period;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        $changed(fb_r) |-> fb_cnt_r == '0 && $past(fb_cnt_r) == FB_LAST;
    endproperty
    a_fallback_period: assert property (p_fallback_period) else $error("fallback period");

    property p_square;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        $changed(sq_r) |-> $past(sq_cnt_r) == ssg_pkg::SQ_HALF_TICKS && $past(pwm_tick_in);
    endproperty
    a_square: assert property (p_square) else $error("square half period");

    property p_chop_fail;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        fail_mode_in |=> $stable(chop_sign_r);
    endproperty
    a_chop_fail: assert property (p_chop_fail) else $error("chopping in fail mode");

    property p_chop_toggle;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (chop_active && strobe_low_r && !strobe_low_nxt) |=> chop_sign_r != $past(chop_sign_r);
    endproperty
    a_chop_toggle: assert property (p_chop_toggle) else $error("sign not inverted");

    property p_full_pulse;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (pwm_cycle_start_in && full_duty_in) |=> hp_cnt_r == HP_LOAD;
    endproperty
    a_full_pulse: assert property (p_full_pulse) else $error("no high pulse");

    c_strobe_low: cover property (@(posedge core_clk_in) $rose(strobe_low_r));
    c_mux_blank: cover property (@(posedge core_clk_in) mux_chg_r ##1 blank_cnt_r != '0);
    c_chop: cover property (@(posedge core_clk_in) chop_sw);
    c_fallback: cover property (@(posedge core_clk_in) pwm_clk_fail_in && strobe_low_r);
endmodule : ssg_strobe_gen

// *** include/ssg_pkg.sv ***
// Constants and types for the sense sample strobe generator.
// Assumes a 100 MHz core clock and a one-cycle PWM clock tick from the PWM block.
package ssg_pkg;
    // ----------------------------------------
    // Register map (APB, 32-bit aligned words)
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam int MODE_LSB = 0;
    localparam int SRC_LSB = 2;
    localparam int CHOP_EN_BIT = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam int ST_STROBE_BIT = 0;
    localparam int ST_CHOP_SIGN_BIT = 1;
    localparam int ST_FAULT_BIT = 2;
    localparam int ST_BLANK_BIT = 3;
    localparam int ST_CHOP_ACT_BIT = 4;
    // Source codes below this value select an output current
    localparam logic [2:0] SRC_FIRST_VOLTAGE = 3'h5;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 10000;
    localparam int FALLBACK_PERIOD_US = 6500;
    // Cycles per microsecond first, so the product stays inside 32 bits
    localparam int FALLBACK_HALF_CYC = FALLBACK_PERIOD_US * (1000000 / CLK_PERIOD_PS) / 2;
    localparam int HIGH_PULSE_US = 100;
    localparam int HIGH_PULSE_CYC = HIGH_PULSE_US * 1000000 / CLK_PERIOD_PS;
    localparam int TURN_ON_DELAY_US = 20;
    localparam int FEEDBACK_SETTLE_US = 30;
    localparam int BLANK_CYC = (TURN_ON_DELAY_US + FEEDBACK_SETTLE_US) * 1000000
        / CLK_PERIOD_PS;
    localparam int SLOW_PRESCALE = 1024;
    localparam logic [9:0] SQ_HALF_TICKS = 10'h1ff;

    typedef enum logic [1:0] {
        SSG_MODE_OFF = 2'b00,
        SSG_MODE_VALID = 2'b01,
        SSG_MODE_AFTER_CYCLE = 2'b10,
        SSG_MODE_SECOND_HALF = 2'b11
    } ssg_mode_t;

    typedef struct packed {
        logic offset_chopping_enable;
        logic [2:0] feedback_source_select;
        ssg_mode_t strobe_mode;
    } ssg_ctrl_t;
endpackage : ssg_pkg

// *** verif/sense_sample_strobe_gen_tb_top.sv ***
// Self-checking bench for the sense sample strobe generator.
// Assumes the APB slave answers with pready; long counts are shortened by parameters.
`timescale 1ns/100ps
module sense_sample_strobe_gen_tb_top;
    localparam int FB_HALF = 20;
    localparam int HP = 5;
    localparam int BLK = 4;
    logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic normal = 1'h1, failm = 1'h0, clkfail = 1'h0, tick = 1'h0, tick_on = 1'h0;
    logic cstart = 1'h0, pwm_on = 1'h0, osw = 1'h0, fduty = 1'h0, hoc = 1'h0;
    logic fault = 1'h0, oen = 1'h0;
    logic pready, pslverr, err, so, soe, sign, pin, s0;
    logic [15:0] cnt, c0;
    int n_mismatch = 0;
    int n_compared = 0;

    ssg_strobe_gen #(.FALLBACK_HALF(FB_HALF), .HIGH_PULSE(HP), .BLANK(BLK)) dut (
        .core_clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .normal_mode_in(normal),
        .fail_mode_in(failm), .pwm_clk_fail_in(clkfail), .pwm_tick_in(tick),
        .pwm_cycle_start_in(cstart), .pwm_on_in(pwm_on), .out_switching_in(osw),
        .full_duty_in(fduty), .high_overcurrent_window_in(hoc), .out_fault_in(fault),
        .out_enable_in(oen), .sense_sample_strobe_o_out(so),
        .sense_sample_strobe_oe_out(soe), .offset_sign_out(sign));

    ssg_adc_sampler adc (.core_clk_in(clk), .sys_rst_in(rst), .strobe_o_in(so),
        .strobe_oe_in(soe), .pin_out(pin), .sample_cnt_out(cnt));

    initial begin
        forever #5 clk = ~clk;
    end

    // PWM clock at half the core rate
    always @(posedge clk) begin
        tick <= tick_on & ~tick;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        pen <= 1'h0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
        if (n >= 50) begin
            n_mismatch++;
            end_of_test();
        end
    endtask : apb

    task automatic set(input logic chop, input logic [2:0] src, input ssg_pkg::ssg_mode_t m);
        apb(1'h1, ssg_pkg::CTRL_OFFSET, {26'h0, chop, src, m});
    endtask : set

    // Pin level is checked through the sampler, so open-drain polarity is covered too
    task automatic see(input string name, input logic exp);
        @(negedge clk);
        check(name, {30'h0, pin, soe}, {30'h0, ~exp, exp});
        @(posedge clk);
    endtask : see

    task automatic pulse(input int on, input int off);
        cstart <= 1'h1;
        pwm_on <= 1'h1;
        step(1);
        cstart <= 1'h0;
        step(on - 1);
        pwm_on <= 1'h0;
        step(off);
    endtask : pulse

    // Skips two levels that may be cut by a switch, then counts one whole level
    task automatic meas(input int exp);
        int n;
        logic v;
        @(negedge clk);
        for (int k = 0; k < 3; k++) begin
            v = soe;
            n = 0;
            while (soe === v && n < 3000) begin
                @(negedge clk);
                n++;
            end
            if (n >= 3000) begin
                n_mismatch++;
                end_of_test();
            end
        end
        check("half_period", n, exp);
        @(posedge clk);
    endtask : meas

    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        step(12);
        rst <= 1'h0;
        step(1);
        see("reset_strobe", 1'h0);
        check("reset_sign", {31'h0, sign}, 32'h0);
        apb(1'h0, ssg_pkg::CTRL_OFFSET, 32'h0);
        check("ctrl_reset", rd, 32'h0);
        apb(1'h0, 8'h08, 32'h0);
        check("unmapped_err", {31'h0, err}, 32'h1);
        check("unmapped_data", rd, 32'h0);
        set(1'h0, 3'h0, ssg_pkg::SSG_MODE_OFF);
        pwm_on <= 1'h1;
        step(BLK + 4);
        see("mode_off", 1'h0);
        set(1'h0, 3'h0, ssg_pkg::SSG_MODE_VALID);
        step(BLK + 4);
        see("valid_on", 1'h1);
        hoc <= 1'h1;
        step(2);
        see("overcurrent", 1'h0);
        hoc <= 1'h0;
        pwm_on <= 1'h0;
        step(2);
        see("off_phase", 1'h0);
        pwm_on <= 1'h1;
        normal <= 1'h0;
        step(2);
        see("not_normal", 1'h0);
        normal <= 1'h1;
        fault <= 1'h1;
        step(1);
        fault <= 1'h0;
        step(4);
        see("fault_held", 1'h0);
        apb(1'h0, ssg_pkg::STATUS_OFFSET, 32'h0);
        check("fault_status", rd, 32'h1 << ssg_pkg::ST_FAULT_BIT);
        oen <= 1'h1;
        step(1);
        oen <= 1'h0;
        step(3);
        see("reenabled", 1'h1);
        set(1'h0, 3'h1, ssg_pkg::SSG_MODE_VALID);
        step(1);
        see("mux_blank", 1'h0);
        step(BLK + 3);
        see("after_blank", 1'h1);
        set(1'h0, 3'h2, ssg_pkg::SSG_MODE_AFTER_CYCLE);
        step(BLK + 4);
        see("wait_cycle", 1'h0);
        cstart <= 1'h1;
        step(1);
        cstart <= 1'h0;
        step(3);
        see("new_cycle", 1'h1);
        fduty <= 1'h1;
        step(2);
        see("full_low", 1'h1);
        cstart <= 1'h1;
        step(1);
        cstart <= 1'h0;
        step(1);
        see("full_pulse", 1'h0);
        step(HP - 3);
        see("full_pulse_end", 1'h0);
        see("full_after", 1'h1);
        fduty <= 1'h0;
        pwm_on <= 1'h0;
        set(1'h0, 3'h2, ssg_pkg::SSG_MODE_SECOND_HALF);
        pulse(10, 6);
        pulse(10, 6);
        cstart <= 1'h1;
        pwm_on <= 1'h1;
        step(1);
        cstart <= 1'h0;
        step(2);
        see("first_half", 1'h0);
        step(4);
        see("second_half", 1'h1);
        pwm_on <= 1'h0;
        step(2);
        see("pulse_end", 1'h0);
        set(1'h1, 3'h2, ssg_pkg::SSG_MODE_VALID);
        step(BLK + 4);
        s0 = sign;
        c0 = cnt;
        repeat (3) pulse(14, 14);
        check("chop_samples", {16'h0, cnt - c0}, 32'h3);
        check("chop_sign", {31'h0, sign}, {31'h0, ~s0});
        failm <= 1'h1;
        step(2);
        s0 = sign;
        repeat (2) pulse(14, 14);
        check("fail_sign", {31'h0, sign}, {31'h0, s0});
        failm <= 1'h0;
        tick_on <= 1'h1;
        // Voltage sources: 512 ticks a level, a tick every second cycle
        for (int s = 5; s < 8; s++) begin
            set(1'h0, s[2:0], ssg_pkg::SSG_MODE_VALID);
            meas(1024);
        end
        clkfail <= 1'h1;
        meas(FB_HALF);
        set(1'h0, 3'h0, ssg_pkg::SSG_MODE_VALID);
        meas(FB_HALF);
        end_of_test();
    end
endmodule : sense_sample_strobe_gen_tb_top

// *** verif/ssg_adc_sampler.sv ***
// Behavioural model of the microcontroller ADC that samples on the strobe pin.
// Assumes an external pull-up on the pin and the same core clock as the strobe generator.
`timescale 1ns/100ps
module ssg_adc_sampler (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic strobe_o_in,
    input wire logic strobe_oe_in,
    output logic pin_out,
    output logic [15:0] sample_cnt_out
);
    logic pin_d_r;

    assign pin_out = strobe_oe_in ? strobe_o_in : 1'h1;

    // count samples per rise
    // A conversion is launched when the pin returns high, so one rise is one sample
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            pin_d_r <= 1'h1;
            sample_cnt_out <= 16'h0000;
        end else begin
            pin_d_r <= pin_out;
            if (pin_out && !pin_d_r) begin
                sample_cnt_out <= sample_cnt_out + 16'h0001;
            end
        end
    end
endmodule : ssg_adc_sampler
